// ==== logic/lcd_pkg.sv ====
// constants and helpers shared by the host interface blocks
package lcd_pkg;
  // interface-mode pin codes
  localparam logic [3:0] MODE_P16 = 4'h2;
  localparam logic [3:0] MODE_P8  = 4'h3;
  localparam logic [3:0] MODE_P18 = 4'hA;
  localparam logic [3:0] MODE_P9  = 4'hB;
  localparam logic [2:0] MODE_SER = 3'h2;
  // resync and serial read figures
  localparam logic [2:0] SYNC_ZERO_WRITES = 3'h4;
  localparam logic [2:0] SER_DUMMY_BYTES  = 3'h5;
  // instruction indexes the block looks at
  localparam logic [15:0] MEM_DATA_INDEX  = 16'h0022;
  localparam logic [15:0] DISP_CTRL_INDEX = 16'h000C;
  localparam int          DISP_MODE_LSB   = 0;
  localparam int          PATH_BIT        = 8;
  localparam logic [1:0]  DISP_MODE_VSYNC = 2'h2;
  // register port map
  localparam logic [3:0]  REG_STATUS    = 4'h0;
  localparam logic [3:0]  REG_CTRL      = 4'h4;
  localparam int          CTRL_TWO_XFER = 0;
  localparam int          CTRL_RESYNC   = 1;
  localparam logic        TWO_XFER_RST  = 1'b0;
  // pin synchroniser width and idle levels (strobes and link clock idle high)
  localparam int           SYNC_W    = 28;
  localparam logic [27:0]  SYNC_INIT = 28'h0C00006;
  // 16-bit 565 word widened to 666, colour msb copied into new lsb
  function automatic logic [17:0] widen565(input logic [15:0] w);
    widen565 = {w[15:11], w[15], w[10:5], w[4:0], w[4]};
  endfunction
endpackage

// ==== logic/word_if.sv ====
// word hand-off from the parallel splitter to the decoder
`timescale 1ns/100ps
interface word_if;
  logic        valid;
  logic        regsel;
  logic [15:0] instr;
  logic [17:0] pix;
  modport src (output valid, regsel, instr, pix);
  modport snk (input valid, regsel, instr, pix);
endinterface

// ==== logic/pin_sync.sv ====
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // raw pins in, synchronised levels out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t st, next_st;

  // first stage feeds the second stage only
  always_comb begin
    next_st.s1 = pin;
    next_st.s2 = st.s1;
  end

  // idle levels at reset so no false strobe edge appears
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= {INIT, INIT};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.s2;
endmodule

// ==== logic/par_split.sv ====
// parallel bus splitter: upper/lower pairing and four-zero resync
`timescale 1ns/100ps
module par_split
  import lcd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // accepted bus write
  input  wire logic        wr_evt,
  input  wire logic        regsel,
  input  wire logic [17:0] data,
  // configuration
  input  wire logic [3:0]  mode,
  input  wire logic        two_xfer,
  input  wire logic        resync,
  // state and words out
  output logic             phase,
  word_if.src              w
);
  typedef struct packed {
    logic        phase;
    logic [2:0]  zc;
    logic [8:0]  upper;
    logic        valid;
    logic        regsel;
    logic [15:0] instr;
    logic [17:0] pix;
  } split_t;
  split_t      st, next_st;
  logic        split;
  logic        zero;
  logic [15:0] w16;
  logic [15:0] w8;

  // unused lanes may be tied either way, so zero looks at used lanes only
  assign w16   = {data[17:10], data[8:1]};
  assign w8    = {st.upper[8:1], data[17:10]};
  assign zero  = (mode == MODE_P8 || mode == MODE_P9) ? (data[17:10] == 8'h00)
                                                      : (w16 == 16'h0000);
  assign split = (mode == MODE_P8) || (mode == MODE_P9) ||
                 (mode == MODE_P16 && two_xfer && regsel);

  // pairing of halves and emission of whole words
  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;
    if (resync) begin
      next_st.phase = 1'b0;
      next_st.zc    = 3'h0;
    end else if (wr_evt) begin
      next_st.zc = zero ? st.zc + 3'h1 : 3'h0;
      if (split && !st.phase) begin
        next_st.phase = 1'b1;
        next_st.upper = data[17:9];
      end else begin
        next_st.phase  = 1'b0;
        next_st.valid  = 1'b1;
        next_st.regsel = regsel;
        case (mode)
          MODE_P9: begin
            next_st.instr = w8;
            next_st.pix   = {st.upper, data[17:9]};
          end
          MODE_P8: begin
            next_st.instr = w8;
            next_st.pix   = widen565(w8);
          end
          MODE_P16: begin
            next_st.instr = w16;
            next_st.pix   = two_xfer ? {st.upper[8:7], w16} : widen565(w16);
          end
          default: begin
            next_st.instr = w16;
            next_st.pix   = data;
          end
        endcase
      end
      if (zero && st.zc == SYNC_ZERO_WRITES - 3'h1) begin
        next_st.phase = 1'b0;
        next_st.zc    = 3'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phase    = st.phase;
  assign w.valid  = st.valid;
  assign w.regsel = st.regsel;
  assign w.instr  = st.instr;
  assign w.pix    = st.pix;

  property p_resync_zero;
    @(posedge clk) disable iff (!nrst)
    (wr_evt && !resync && zero && st.zc == 3'h3) |=> (st.phase == 1'b0 && st.zc == 3'h0);
  endproperty
  a_resync_zero: assert property (p_resync_zero)
    else $error("fourth zero write did not resync the halves");

  property p_upper_held;
    @(posedge clk) disable iff (!nrst)
    (wr_evt && !resync && split && !st.phase && !zero) |=> (!st.valid && st.phase);
  endproperty
  a_upper_held: assert property (p_upper_held)
    else $error("upper half produced a word");
endmodule

// ==== logic/lcd_host_system_interface.sv ====
// device-side host system interface: split parallel bus and serial link
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
// Notes on behaviour
// - mode pins statically choose the bus
// - 16-bit two-transfer: four zeros resync halves
// - 9-bit: four zero writes resync halves
// - 8-bit: four zero writes resync halves
// - 9-bit instruction: two bytes, lsb ignored
// - 9-bit pixel: two nine-bit halves
// - 8-bit pixel: byte pair widened to 18
// - serial when upper pins low-high-low
// - chip select frames each serial transaction
// - start-byte address must match own code
// - upper code fixed, lsb from pin
// - start byte flags select index/write/read
// - direction flag picks input or output
// - msb first bytes, instruction after two
// - serial pixel widened with msb copies
// - memory read: five dummy bytes first
// - display mode 10, path 0: vsync mode
module lcd_host_system_interface
  import lcd_pkg::*;
#(
  parameter logic [4:0] IDENT_UPPER = 5'h15  // arbitrary identity value
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // mode straps, bit 0 doubles as identity select
  input  wire logic [3:0]  interface_mode_pins,
  // parallel bus
  input  wire logic        par_cs_n,
  input  wire logic        par_wr_n,
  input  wire logic        par_regsel,
  input  wire logic [17:0] parallel_data_bus,
  // serial link
  input  wire logic        ser_cs_n,
  input  wire logic        ser_clk,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // core side
  input  wire logic [15:0] read_data,
  output logic             read_advance,
  output logic             instr_strobe,
  output logic      [15:0] instr_index,
  output logic      [15:0] instr_data,
  output logic             pixel_strobe,
  output logic      [17:0] pixel_data,
  output logic             vsync_mode
);
  typedef struct packed {
    logic        wr_prev;
    logic        sclk_prev;
    logic        two_xfer;
    logic        resync;
    logic [15:0] index;
    logic        vsync;
    logic [2:0]  bitc;
    logic [7:0]  sh;
    logic        started;
    logic        sel;
    logic        s_regsel;
    logic        s_rw;
    logic        s_mem;
    logic        half;
    logic [7:0]  hi;
    logic [2:0]  bytec;
    logic [7:0]  osh;
    logic        so_bit;
    logic        so_oe;
    logic        rd_adv;
    logic        i_stb;
    logic [15:0] i_idx;
    logic [15:0] i_dat;
    logic        p_stb;
    logic [17:0] p_dat;
    logic [31:0] rdata;
  } top_t;
  top_t st, next_st;

  logic [SYNC_W-1:0] sy;
  logic [3:0]        mode;
  logic              p_cs_n;
  logic              p_wr_n;
  logic              p_regsel;
  logic [17:0]       p_data;
  logic              s_cs_n;
  logic              s_clk;
  logic              s_din;
  logic              ser_mode;
  logic              mode_ok;
  logic              wr_evt;
  logic              sclk_rise;
  logic              sclk_fall;
  logic [7:0]        byte_in;
  logic              s_v;
  logic              load;
  logic              dummy;
  logic [7:0]        obyte;
  logic              word_v;
  logic              word_regsel;
  logic [15:0]       word_w16;
  logic [17:0]       word_pix;
  logic              vs_new;
  logic              phase;
  logic [31:0]       status;

  word_if pw ();

  // every pin is synchronised, the link clock included
  pin_sync #(
    .W    (SYNC_W),
    .INIT (SYNC_INIT)
  ) u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   ({interface_mode_pins, par_cs_n, par_wr_n, par_regsel,
             parallel_data_bus, ser_cs_n, ser_clk, serial_data_in}),
    .level (sy)
  );

  assign mode     = sy[27:24];
  assign p_cs_n   = sy[23];
  assign p_wr_n   = sy[22];
  assign p_regsel = sy[21];
  assign p_data   = sy[20:3];
  assign s_cs_n   = sy[2];
  assign s_clk    = sy[1];
  assign s_din    = sy[0];

  assign ser_mode = (mode[3:1] == MODE_SER);
  // inhibited codes leave the block deaf
  assign mode_ok  = ser_mode || mode == MODE_P16 || mode == MODE_P8 ||
                    mode == MODE_P18 || mode == MODE_P9;

  // data is taken at the rising edge of the write strobe
  assign wr_evt    = mode_ok && !ser_mode && !p_cs_n && p_wr_n && !st.wr_prev;
  assign sclk_rise = s_clk && !st.sclk_prev;
  assign sclk_fall = !s_clk && st.sclk_prev;
  assign byte_in   = {st.sh[6:0], s_din};

  assign s_v = ser_mode && !s_cs_n && sclk_rise && st.bitc == 3'h7 &&
               st.started && st.sel && !st.s_rw && st.half;

  // read byte loads at the first falling edge of each byte
  assign load  = ser_mode && !s_cs_n && sclk_fall && st.started && st.sel &&
                 st.s_rw && st.bitc == 3'h0;
  // memory reads lead with dummy bytes
  assign dummy = st.s_mem && st.bytec < SER_DUMMY_BYTES;

  // one decoder serves whichever bus the straps chose
  assign word_v      = ser_mode ? s_v : pw.valid;
  assign word_regsel = ser_mode ? st.s_regsel : pw.regsel;
  assign word_w16    = ser_mode ? {st.hi, byte_in} : pw.instr;
  assign word_pix    = ser_mode ? widen565({st.hi, byte_in}) : pw.pix;

  assign vs_new = (word_w16[DISP_MODE_LSB +: 2] == DISP_MODE_VSYNC) &&
                  !word_w16[PATH_BIT];

  // status: phase, bus ok, serial, vsync, mode pins, index
  assign status = {8'h00, phase, mode_ok, ser_mode, st.vsync, mode, st.index};

  par_split u_split (
    .clk      (clk),
    .nrst     (nrst),
    .wr_evt   (wr_evt),
    .regsel   (p_regsel),
    .data     (p_data),
    .mode     (mode),
    .two_xfer (st.two_xfer),
    .resync   (st.resync),
    .phase    (phase),
    .w        (pw)
  );

  // decoder, serial engine and register port
  always_comb begin
    next_st           = st;
    obyte             = 8'h00;
    next_st.wr_prev   = p_wr_n;
    next_st.sclk_prev = s_clk;
    next_st.resync    = 1'b0;
    next_st.rd_adv    = 1'b0;
    next_st.i_stb     = 1'b0;
    next_st.p_stb     = 1'b0;
    next_st.rdata     = 32'h0000_0000;

    if (word_v) begin
      if (!word_regsel) begin
        next_st.index = word_w16;
      end else if (st.index == MEM_DATA_INDEX) begin
        next_st.p_stb = 1'b1;
        next_st.p_dat = word_pix;
      end else begin
        next_st.i_stb = 1'b1;
        next_st.i_idx = st.index;
        next_st.i_dat = word_w16;
        if (st.index == DISP_CTRL_INDEX) begin
          next_st.vsync = vs_new;
        end
      end
    end

    if (!ser_mode || s_cs_n) begin
      next_st.bitc    = 3'h0;
      next_st.started = 1'b0;
      next_st.sel     = 1'b0;
      next_st.half    = 1'b0;
      next_st.bytec   = 3'h0;
      next_st.so_bit  = 1'b0;
    end else if (sclk_rise) begin
      next_st.sh   = byte_in;
      next_st.bitc = st.bitc + 3'h1;
      if (st.bitc == 3'h7) begin
        if (!st.started) begin
          next_st.started  = 1'b1;
          next_st.sel      = byte_in[7:2] == {IDENT_UPPER, mode[0]} &&
                             !(!byte_in[1] && byte_in[0]);
          next_st.s_regsel = byte_in[1];
          next_st.s_rw     = byte_in[0];
          next_st.s_mem    = st.index == MEM_DATA_INDEX;
          next_st.half     = 1'b0;
        end else if (st.sel && !st.s_rw) begin
          next_st.hi   = st.half ? st.hi : byte_in;
          next_st.half = !st.half;
        end
      end
    end else if (load) begin
      // dummy then word, upper byte first
      if (dummy) begin
        obyte         = 8'h00;
        next_st.bytec = st.bytec + 3'h1;
      end else if (!st.half) begin
        obyte        = read_data[15:8];
        next_st.hi   = read_data[7:0];
        next_st.half = 1'b1;
      end else begin
        obyte          = st.hi;
        next_st.half   = 1'b0;
        next_st.rd_adv = 1'b1;
      end
      next_st.so_bit = obyte[7];
      next_st.osh    = {obyte[6:0], 1'b0};
    end else if (ser_mode && sclk_fall && st.started && st.sel && st.s_rw) begin
      next_st.so_bit = st.osh[7];
      next_st.osh    = {st.osh[6:0], 1'b0};
    end
    // drive out only on a selected read
    next_st.so_oe = ser_mode && !s_cs_n && next_st.started && next_st.sel &&
                    next_st.s_rw;

    // register port, answer in the next cycle only
    if (reg_wr && reg_addr == REG_CTRL) begin
      next_st.two_xfer = reg_wdata[CTRL_TWO_XFER];
      next_st.resync   = reg_wdata[CTRL_RESYNC];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: next_st.rdata = status;
        REG_CTRL:   next_st.rdata = {31'h0000_0000, st.two_xfer};
        default:    next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // state register; strobes and link clock idle high so no false edge follows reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st           <= '0;
      st.wr_prev   <= 1'b1;
      st.sclk_prev <= 1'b1;
      st.two_xfer <= TWO_XFER_RST;
    end else begin
      st <= next_st;
    end
  end

  // every output straight from the state register
  assign serial_data_out    = st.so_bit;
  assign serial_data_out_oe = st.so_oe;
  assign reg_rdata          = st.rdata;
  assign read_advance       = st.rd_adv;
  assign instr_strobe       = st.i_stb;
  assign instr_index        = st.i_idx;
  assign instr_data         = st.i_dat;
  assign pixel_strobe       = st.p_stb;
  assign pixel_data         = st.p_dat;
  assign vsync_mode         = st.vsync;

  property p_pixel_index;
    @(posedge clk) disable iff (!nrst)
    st.p_stb |-> (st.index == MEM_DATA_INDEX && !st.i_stb);
  endproperty
  a_pixel_index: assert property (p_pixel_index)
    else $error("pixel strobe outside the memory data index");

  property p_vsync_cause;
    @(posedge clk) disable iff (!nrst)
    $changed(st.vsync) |-> $past(word_v && word_regsel && st.index == DISP_CTRL_INDEX);
  endproperty
  a_vsync_cause: assert property (p_vsync_cause)
    else $error("vsync mode changed without a control write");

  property p_forbidden;
    @(posedge clk) disable iff (!nrst)
    $rose(st.sel) |-> !(!st.s_regsel && st.s_rw);
  endproperty
  a_forbidden: assert property (p_forbidden)
    else $error("forbidden start byte selected the device");

  property p_ser_word;
    @(posedge clk) disable iff (!nrst)
    s_v |-> (st.sel && !st.s_rw && st.half) ##1 (st.i_stb || st.p_stb || !st.half);
  endproperty
  a_ser_word: assert property (p_ser_word)
    else $error("serial word taken outside a selected write");

  property p_deselect;
    @(posedge clk) disable iff (!nrst)
    (s_cs_n && ser_mode) |=> (st.bitc == 3'h0 && !st.started && !st.so_oe);
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("serial counters not cleared while deselected");

  property p_dummy;
    @(posedge clk) disable iff (!nrst)
    (load && dummy) |=> (!st.so_bit && st.bytec == $past(st.bytec) + 3'h1);
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy read byte not zero or not counted");

  property p_mismatch;
    @(posedge clk) disable iff (!nrst)
    (st.started && !st.sel) |-> (!s_v && !st.so_oe);
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("unaddressed transaction was acted on");
endmodule

// ==== verification/host_model.sv ====
// host microcontroller model: parallel write cycles and serial link frames
`timescale 1ns/100ps
module host_model (
  // clock
  input  wire logic        clk,
  // parallel bus
  output logic             par_cs_n,
  output logic             par_wr_n,
  output logic             par_regsel,
  output logic      [17:0] parallel_data_bus,
  // serial link
  input  wire logic        serial_data_out,
  output logic             ser_cs_n,
  output logic             ser_clk,
  output logic             serial_data_in
);
  // idle at time zero: deselected, link clock parked high
  initial begin
    par_cs_n = 1'b1;
    par_wr_n = 1'b1;
    par_regsel = 1'b0;
    parallel_data_bus = 18'h00000;
    ser_cs_n = 1'b1;
    ser_clk = 1'b1;
    serial_data_in = 1'b0;
  end
  // every half is a full strobe cycle
  task automatic par_wr(input logic rs, input logic [17:0] d);
    @(posedge clk);
    par_cs_n <= 1'b0;
    par_regsel <= rs;
    parallel_data_bus <= d;
    par_wr_n <= 1'b0;
    repeat (4) @(posedge clk);
    par_wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    par_cs_n <= 1'b1;
    parallel_data_bus <= ~d;  // released bus must not look stable
  endtask
  task automatic ser_open;
    @(posedge clk);
    ser_cs_n <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // chip select closes it, gap long enough for the sync
  task automatic ser_close;
    @(posedge clk);
    ser_cs_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
    repeat (4) @(posedge clk);
  endtask
  // msb first; 4 clk per phase gives a 320 ns link period
  task automatic ser_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      ser_clk <= 1'b0;
      serial_data_in <= tx[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (3) @(posedge clk);
      rx[i] = serial_data_out;  // late in the high phase, output long settled
    end
  endtask
endmodule

// ==== verification/tb_lcd_host_system_interface.sv ====
// self-checking bench for the device-side host system interface
`timescale 1ns/100ps
module tb_lcd_host_system_interface;
  import lcd_pkg::*;
  // arbitrary identity value handed to the design
  localparam logic [4:0] ID_HI = 5'h0B;
  // arbitrary core instruction that turns on fast memory writes
  localparam logic [15:0] FAST_WR_INDEX = 16'h0010;
  localparam logic [15:0] FAST_WR_DATA  = 16'h0001;
  logic        clk, nrst, par_cs_n, par_wr_n, par_regsel, ser_cs_n, ser_clk;
  logic        serial_data_in, serial_data_out, serial_data_out_oe, reg_wr, reg_rd;
  logic        read_advance, instr_strobe, pixel_strobe, vsync_mode;
  logic [3:0]  interface_mode_pins, reg_addr;
  logic [17:0] parallel_data_bus, pixel_data;
  logic [15:0] read_data, instr_index, instr_data;
  logic [31:0] reg_wdata, reg_rdata;
  int          bad_count, n_tests, ni, np, na;

  lcd_host_system_interface #(.IDENT_UPPER(ID_HI)) uut (
    .clk(clk), .nrst(nrst), .interface_mode_pins(interface_mode_pins),
    .par_cs_n(par_cs_n), .par_wr_n(par_wr_n), .par_regsel(par_regsel),
    .parallel_data_bus(parallel_data_bus), .ser_cs_n(ser_cs_n), .ser_clk(ser_clk),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .read_data(read_data), .read_advance(read_advance), .instr_strobe(instr_strobe),
    .instr_index(instr_index), .instr_data(instr_data), .pixel_strobe(pixel_strobe),
    .pixel_data(pixel_data), .vsync_mode(vsync_mode));
  host_model host (
    .clk(clk), .par_cs_n(par_cs_n), .par_wr_n(par_wr_n), .par_regsel(par_regsel),
    .parallel_data_bus(parallel_data_bus), .serial_data_out(serial_data_out),
    .ser_cs_n(ser_cs_n), .ser_clk(ser_clk), .serial_data_in(serial_data_in));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // tally one-cycle pulses so no scenario can miss one
  always @(posedge clk) begin
    if (instr_strobe === 1'b1) ni++;
    if (pixel_strobe === 1'b1) np++;
    if (read_advance === 1'b1) na++;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for a strobe tally; running out ends the run
  task automatic wt(input int k, input int e);
    for (int c = 0; c < 40 && (k ? np : ni) != e; c++) @(posedge clk);
    if ((k ? np : ni) != e) begin
      bad_count++;
      $display("[FAIL] t=%0t tally %h exp %h", $time, k ? np : ni, e);
      end_of_test;
    end
  endtask
  // register port: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic setm(input logic [3:0] m);
    @(posedge clk);
    interface_mode_pins <= m;
    repeat (4) @(posedge clk);
  endtask
  // lane placement per bus width
  task automatic p8(input logic rs, input logic [7:0] b);
    host.par_wr(rs, {b, 10'h000});
  endtask
  task automatic p9(input logic rs, input logic [8:0] h);
    host.par_wr(rs, {h, 9'h000});
  endtask
  task automatic p16(input logic rs, input logic [15:0] w);
    host.par_wr(rs, {w[15:8], 1'b0, w[7:0], 1'b0});
  endtask
  task automatic sx(input logic idb, input logic [1:0] f, input logic [15:0] w);
    logic [7:0] r;
    host.ser_open;
    host.ser_byte({ID_HI, idb, f}, r);
    host.ser_byte(w[15:8], r);
    host.ser_byte(w[7:0], r);
    host.ser_close;
  endtask

  task automatic t_regs;
    rdc(REG_STATUS, 32'h00430000);
    rdc(REG_CTRL, 32'h00000000);
    rdc(4'h8, 32'h00000000);
    wr(4'h8, 32'hFFFFFFFF);
    rdc(REG_CTRL, 32'h00000000);
    wr(REG_CTRL, 32'h00000003);
    rdc(REG_CTRL, 32'h00000001);
    wr(REG_CTRL, 32'h00000000);
  endtask
  task automatic t_p8;
    int p0;
    repeat (4) p8(1'b0, 8'h00);
    p8(1'b0, 8'h00);
    rdc(REG_STATUS, 32'h00C30000);
    wr(REG_CTRL, 32'h00000002);
    rdc(REG_STATUS, 32'h00430000);
    p8(1'b0, 8'h00);
    p8(1'b0, 8'h22);
    rdc(REG_STATUS, 32'h00430022);
    p0 = np;
    p8(1'b1, 8'hF8);
    chk(32'(np), 32'(p0));
    p8(1'b1, 8'h00);
    wt(1, p0 + 1);
    chk(32'(pixel_data), 32'h0003F000);
  endtask
  task automatic t_sync;
    int i0;
    // stray upper half, then the four zeros must realign
    p8(1'b0, 8'hAB);
    repeat (4) p8(1'b0, 8'h00);
    p8(1'b0, 8'h00);
    p8(1'b0, 8'h0C);
    i0 = ni;
    p8(1'b1, 8'h00);
    p8(1'b1, 8'h02);
    wt(0, i0 + 1);
    chk(32'(instr_index), 32'h0000000C);
    chk(32'(instr_data), 32'h00000002);
    repeat (2) @(posedge clk);
    chk(32'(vsync_mode), 32'h00000001);
    p8(1'b1, 8'h01);
    p8(1'b1, 8'h02);
    wt(0, i0 + 2);
    repeat (2) @(posedge clk);
    chk(32'(vsync_mode), 32'h00000000);
  endtask
  task automatic t_p9;
    int p0;
    setm(4'hB);
    repeat (4) p9(1'b0, 9'h000);
    p9(1'b0, 9'h000);
    p9(1'b0, 9'h045);
    rdc(REG_STATUS, 32'h004B0022);
    p0 = np;
    p9(1'b1, 9'h1AB);
    p9(1'b1, 9'h055);
    wt(1, p0 + 1);
    chk(32'(pixel_data), {14'h0000, 9'h1AB, 9'h055});
  endtask
  task automatic t_p16;
    int p0;
    setm(4'h2);
    wr(REG_CTRL, 32'h00000001);
    repeat (4) p16(1'b0, 16'h0000);
    p16(1'b0, 16'h0022);
    p0 = np;
    host.par_wr(1'b1, 18'h20000);
    host.par_wr(1'b1, {8'h12, 1'b0, 8'h34, 1'b0});
    wt(1, p0 + 1);
    chk(32'(pixel_data), 32'h00021234);
    wr(REG_CTRL, 32'h00000000);
  endtask
  task automatic t_ser;
    int i0;
    int p0;
    int a0;
    logic [7:0] r;
    setm(4'h5);
    i0 = ni;
    sx(1'b1, 2'b00, 16'h000C);
    sx(1'b1, 2'b10, 16'h0012);
    wt(0, i0 + 1);
    chk(32'(instr_index), 32'h0000000C);
    chk(32'(instr_data), 32'h00000012);
    // vsync mode is on: fast writes first, then frame data back to back
    sx(1'b1, 2'b00, FAST_WR_INDEX);
    sx(1'b1, 2'b10, FAST_WR_DATA);
    wt(0, i0 + 2);
    chk(32'(instr_index), 32'(FAST_WR_INDEX));
    sx(1'b1, 2'b00, 16'h0022);
    p0 = np;
    sx(1'b1, 2'b10, 16'hF81F);
    wt(1, p0 + 1);
    chk(32'(pixel_data), 32'h0003F03F);
    rdc(REG_STATUS, 32'h00750022);
    // odd trailing byte, then a foreign address: no pixel from either
    host.ser_open;
    host.ser_byte({ID_HI, 3'b110}, r);
    host.ser_byte(8'h55, r);
    host.ser_close;
    sx(1'b0, 2'b10, 16'h0034);
    chk(32'(np), 32'(p0 + 1));
    // a leftover byte would pair with the first byte of this frame
    sx(1'b1, 2'b10, 16'h0034);
    wt(1, p0 + 2);
    chk(32'(pixel_data), 32'h00000069);
    // forbidden flag pair keeps the output undriven
    host.ser_open;
    host.ser_byte({ID_HI, 3'b101}, r);
    repeat (2) @(posedge clk);
    chk(32'(serial_data_out_oe), 32'h00000000);
    host.ser_close;
    // memory read after a deselect: dummies first, then the word
    a0 = na;
    @(posedge clk);
    read_data <= 16'hA5C3;
    host.ser_open;
    host.ser_byte({ID_HI, 3'b111}, r);
    repeat (2) @(posedge clk);
    chk(32'(serial_data_out_oe), 32'h00000001);
    for (int k = 0; k < 5; k++) begin
      host.ser_byte(8'h00, r);
      chk(32'(r), 32'h00000000);
    end
    host.ser_byte(8'h00, r);
    chk(32'(r), 32'h000000A5);
    host.ser_byte(8'h00, r);
    chk(32'(r), 32'h000000C3);
    host.ser_close;
    chk(32'(na), 32'(a0 + 1));
    // instruction read: no dummies, the word comes at once
    sx(1'b1, 2'b00, 16'h000C);
    host.ser_open;
    host.ser_byte({ID_HI, 3'b111}, r);
    host.ser_byte(8'h00, r);
    chk(32'(r), 32'h000000A5);
    host.ser_byte(8'h00, r);
    chk(32'(r), 32'h000000C3);
    host.ser_close;
    chk(32'(na), 32'(a0 + 2));
  endtask

  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    interface_mode_pins = 4'h3;
    reg_addr = 4'h0;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    read_data = 16'h0000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t_regs;
    t_p8;
    t_sync;
    t_p9;
    t_p16;
    t_ser;
    end_of_test;
  end
endmodule
